/* File: hw/target_supply_supervisor.sv */
// Target supply supervisor: regulator enable, window monitor, status lamp.
// Assumes a converter delivering the rail in mV and an external
// non-volatile store that holds the setting across power cycles.
`timescale 1ns/1ps
// Function
// - Disable the regulator while the supply disable input is low, enable it when it floats high.
// - A fall of the supply disable input is caught as an edge and turns the enable off; a high level in the off state turns it on.
// - A rail more than 100 mV off the setting flags an error and turns the regulator off.
// - A rail under the window makes the lamp blink rapidly.
// - A rail over the window keeps the lamp steadily lit.
// - After an outside voltage goes away the lamp blinks until the regulator is back on.
// - Requested settings outside 1.8 V to 5.5 V are clamped to those limits.
// - The setting driven to the regulator stays inside its 1.7 V to 5.1 V range.
// - The setting defaults to 3.3 V when the store holds nothing valid.
// - Every accepted setting is written to non-volatile storage and reloaded on start.
// - The setting has 1 mV resolution, finer than 5 mV.
// - A new setting stays pending until the next debugger access applies it.
module target_supply_supervisor #(
    parameter int unsigned SAMPLE_CYCLES = tss_pkg::SAMPLE_CYC,
    parameter int unsigned BLINK_CYCLES = tss_pkg::BLINK_CYC,
    parameter int unsigned RECOVER_CYCLES = tss_pkg::RECOVER_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Supply disable pin, low means external supply
    input wire logic supply_disable_input,
    // Measured target rail in mV
    input wire logic [15:0] target_rail_pin,
    // Host setting request and debugger access strobe
    input wire logic set_req,
    input wire logic [15:0] set_mv,
    input wire logic host_access,
    // Non-volatile store
    input wire logic nv_valid,
    input wire logic [15:0] nv_mv,
    output logic nv_write,
    output logic [15:0] nv_wdata,
    // Regulator control
    output logic reg_enable,
    output logic [15:0] reg_setpoint_mv,
    // Status
    output logic rail_error,
    output logic status_led,
    output logic pending
);
    // Clamp a value into a range
    function automatic logic [15:0] clamp_mv(input logic [15:0] v, input logic [15:0] lo,
                                             input logic [15:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction : clamp_mv

    // Supervisor state and start-up reload flag
    tss_pkg::tss_state_e state_q, state_d;
    logic loaded_q, loaded_d;
    // Pin level seen at the last edge
    logic pin_q, pin_d;
    // Applied and pending settings
    logic [15:0] set_q, set_d;
    logic [15:0] pend_q, pend_d;
    logic pend_v_q, pend_v_d;
    // Store write pulse and its data
    logic nvw_q, nvw_d;
    logic [15:0] nvd_q, nvd_d;
    // Sample, blink and recovery timers
    logic [31:0] samp_q, samp_d;
    logic [31:0] blink_q, blink_d;
    logic [31:0] rec_q, rec_d;
    logic phase_q, phase_d;
    // Rail position at the last sample
    logic low_q, low_d;
    logic high_q, high_d;
    // Error flag and lamp
    logic err_q, err_d;
    logic led_q, led_d;
    // Window edges and strobes
    logic [15:0] win_lo, win_hi;
    logic pin_edge, tick;

    // Window edges around the applied setting
    assign win_lo = set_q - tss_pkg::MV_WINDOW;
    assign win_hi = set_q + tss_pkg::MV_WINDOW;
    // Pin change against the last level, idle high so reset gives no false edge
    assign pin_edge = pin_q != supply_disable_input;
    // One strobe per sample period drives every window decision
    assign tick = samp_q == SAMPLE_CYCLES - 1;

    // Next-state logic
    always_comb begin
        // Hold state and settings unless a branch below moves them; sample and blink timers run, recovery timer holds, pin follows input, write pulse clears
        state_d = state_q;
        loaded_d = 1'b1;
        pin_d = supply_disable_input;
        set_d = set_q;
        pend_d = pend_q;
        pend_v_d = pend_v_q;
        nvw_d = 1'b0;
        nvd_d = nvd_q;
        samp_d = tick ? 32'h0 : samp_q + 32'h1;
        blink_d = (blink_q == BLINK_CYCLES - 1) ? 32'h0 : blink_q + 32'h1;
        phase_d = (blink_q == BLINK_CYCLES - 1) ? ~phase_q : phase_q;
        rec_d = rec_q;
        low_d = low_q;
        high_d = high_q;
        err_d = err_q;
        // Setting reload at start
        if (!loaded_q) begin
            set_d = nv_valid ? clamp_mv(nv_mv, tss_pkg::MV_LIMIT_LO,
                                        tss_pkg::MV_LIMIT_HI)
                             : tss_pkg::MV_DEFAULT;
        end
        // Host request held pending
        if (set_req) begin
            pend_d = clamp_mv(set_mv, tss_pkg::MV_LIMIT_LO, tss_pkg::MV_LIMIT_HI);
            pend_v_d = 1'b1;
        end else if (host_access && pend_v_q) begin
            set_d = pend_q;
            pend_v_d = 1'b0;
            nvw_d = 1'b1;
            nvd_d = pend_q;
        end
        // Periodic window sample
        if (tick) begin
            low_d = target_rail_pin < win_lo;
            high_d = target_rail_pin > win_hi;
        end
        // Regulator state machine, pin edges take priority
        case (state_q)
            tss_pkg::TSS_OFF: begin
                if (supply_disable_input) begin
                    state_d = tss_pkg::TSS_ON;
                end
            end
            tss_pkg::TSS_ON: begin
                // Pin is high on entry, so a low level always shows as an edge
                if (pin_edge && !supply_disable_input) begin
                    state_d = tss_pkg::TSS_OFF;
                end else if (tick && (low_d || high_d)) begin
                    state_d = tss_pkg::TSS_FAULT;
                    err_d = 1'b1;
                    rec_d = 32'h0;
                end
            end
            tss_pkg::TSS_FAULT: begin
                // Pin pulled low hands the rail to the outside source
                if (pin_edge && !supply_disable_input) begin
                    state_d = tss_pkg::TSS_OFF;
                    err_d = 1'b0;
                end else if (tick) begin
                    // With the regulator off an absent outside source reads low
                    if (high_d) begin
                        rec_d = 32'h0;
                    end else if (rec_q + SAMPLE_CYCLES >= RECOVER_CYCLES) begin
                        state_d = tss_pkg::TSS_ON;
                        err_d = 1'b0;
                    end else begin
                        rec_d = rec_q + SAMPLE_CYCLES;
                    end
                end
            end
            default: begin
                state_d = tss_pkg::TSS_OFF;
            end
        endcase
        // Lamp: blink under window or while waiting, steady otherwise
        // High flag lags by up to one sample, so the lamp follows a tick
        if (state_q == tss_pkg::TSS_FAULT && !high_q) begin
            led_d = phase_q;
        end else begin
            led_d = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= tss_pkg::TSS_OFF;
            loaded_q <= 1'b0;
            pin_q <= 1'b1;
            set_q <= tss_pkg::MV_DEFAULT;
            pend_q <= tss_pkg::MV_DEFAULT;
            pend_v_q <= 1'b0;
            nvw_q <= 1'b0;
            nvd_q <= tss_pkg::MV_DEFAULT;
            samp_q <= 32'h0;
            blink_q <= 32'h0;
            rec_q <= 32'h0;
            phase_q <= 1'b0;
            low_q <= 1'b0;
            high_q <= 1'b0;
            err_q <= 1'b0;
            led_q <= 1'b0;
        end else begin
            state_q <= state_d;
            loaded_q <= loaded_d;
            pin_q <= pin_d;
            set_q <= set_d;
            pend_q <= pend_d;
            pend_v_q <= pend_v_d;
            nvw_q <= nvw_d;
            nvd_q <= nvd_d;
            samp_q <= samp_d;
            blink_q <= blink_d;
            rec_q <= rec_d;
            phase_q <= phase_d;
            low_q <= low_d;
            high_q <= high_d;
            err_q <= err_d;
            led_q <= led_d;
        end
    end

    // Outputs
    assign reg_enable = state_q == tss_pkg::TSS_ON;
    assign reg_setpoint_mv = clamp_mv(set_q, tss_pkg::MV_HW_LO, tss_pkg::MV_HW_HI);
    assign nv_write = nvw_q;
    assign nv_wdata = nvd_q;
    assign rail_error = err_q;
    assign status_led = led_q;
    assign pending = pend_v_q;
endmodule : target_supply_supervisor

/* File: hw/tss_pkg.sv */
// Constants for the target supply supervisor.
// Assumes all voltages in millivolts, 16-bit unsigned, clock at 100 MHz.
package tss_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam logic [15:0] MV_WINDOW = 16'h0064;      // 100 mV either side
    localparam logic [15:0] MV_LIMIT_LO = 16'h0708;    // 1800 mV
    localparam logic [15:0] MV_LIMIT_HI = 16'h157c;    // 5500 mV
    localparam logic [15:0] MV_HW_LO = 16'h06a4;       // 1700 mV
    localparam logic [15:0] MV_HW_HI = 16'h13ec;       // 5100 mV
    localparam logic [15:0] MV_DEFAULT = 16'h0ce4;     // 3300 mV
    localparam logic [15:0] MV_STEP = 16'h0001;        // 1 mV resolution
    // Sampling period of the window comparison
    localparam int unsigned SAMPLE_US = 10;
    localparam int unsigned SAMPLE_CYC = SAMPLE_US * (CLK_HZ / 1_000_000);
    // Rapid blink half period
    localparam int unsigned BLINK_MS = 50;
    localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
    // Over-window samples must be absent for this long before the regulator returns
    localparam int unsigned RECOVER_MS = 100;
    localparam int unsigned RECOVER_CYC = RECOVER_MS * (CLK_HZ / 1000);
    typedef enum logic [1:0] {TSS_OFF, TSS_ON, TSS_FAULT} tss_state_e;
endpackage : tss_pkg

/* File: sim/tb_target_supply_supervisor.sv */
// Self-checking bench for the supervisor.
// Assumes short counts: sample 4, blink 4, recover 16.
`timescale 1ns/1ps
module tb_target_supply_supervisor;
    logic clk_sys = 0, sys_rst = 1, supply_disable_input = 1, set_req = 0, host_access = 0;
    logic nv_valid = 0, ext_on = 0, nv_write, reg_enable, rail_error, status_led, pending;
    logic [15:0] set_mv = 0, nv_mv = 0, ext_mv = 0, target_rail_pin, nv_wdata, reg_setpoint_mv, v;
    logic [15:0] exp_q[$];
    logic lamp;
    int err_count = 0, num_checks = 0;
    // Clock
    always #5 clk_sys = ~clk_sys;
    target_supply_supervisor #(.SAMPLE_CYCLES(4), .BLINK_CYCLES(4), .RECOVER_CYCLES(16)) u_dut (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .supply_disable_input(supply_disable_input),
        .target_rail_pin(target_rail_pin),
        .set_req(set_req),
        .set_mv(set_mv),
        .host_access(host_access),
        .nv_valid(nv_valid),
        .nv_mv(nv_mv),
        .nv_write(nv_write),
        .nv_wdata(nv_wdata),
        .reg_enable(reg_enable),
        .reg_setpoint_mv(reg_setpoint_mv),
        .rail_error(rail_error),
        .status_led(status_led),
        .pending(pending)
    );
    tss_rail_model u_rail (
        .reg_enable(reg_enable),
        .reg_setpoint_mv(reg_setpoint_mv),
        .ext_on(ext_on),
        .ext_mv(ext_mv),
        .rail_mv(target_rail_pin)
    );
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk16
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask : chk1
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic do_reset(input logic valid, input logic [15:0] mv);
        nv_valid = valid;
        nv_mv = mv;
        sys_rst = 1;
        cyc(10);
        sys_rst = 0;
        cyc(3);
    endtask : do_reset
    // Request, then debugger access; the watcher checks the stored value
    task automatic apply(input logic [15:0] mv, input logic [15:0] want);
        set_req = 1;
        set_mv = mv;
        cyc(1);
        set_req = 0;
        chk1(pending, 1);
        host_access = 1;
        exp_q.push_back(want);
        cyc(1);
        host_access = 0;
        chk1(pending, 0);
        cyc(2);
        chk16(reg_setpoint_mv, want);
    endtask : apply
    task automatic wait_on();
        for (int k = 0; k < 100 && reg_enable !== 1'b1; k++) cyc(1);
    endtask : wait_on
    // Watcher of non-volatile writes
    always @(negedge clk_sys) begin
        if (nv_write === 1'b1 && exp_q.size() == 0) chk1(1'b0, 1'b1);
        else if (nv_write === 1'b1) chk16(nv_wdata, exp_q.pop_front());
    end
    initial begin
        void'($urandom(32'h50d0));
        do_reset(0, 16'h0000);
        chk16(reg_setpoint_mv, tss_pkg::MV_DEFAULT);
        chk1(reg_enable, 1);
        supply_disable_input = 0;
        cyc(1);
        chk1(reg_enable, 0);
        supply_disable_input = 1;
        cyc(1);
        chk1(reg_enable, 1);
        apply(16'h03e8, tss_pkg::MV_LIMIT_LO);
        for (int i = 0; i < 6; i++) begin
            v = 16'(tss_pkg::MV_LIMIT_LO + $urandom_range(3300));
            apply(v, v);
        end
        set_req = 1;
        set_mv = 16'h0bb8;
        cyc(1);
        apply(16'h0fa0, 16'h0fa0);
        do_reset(1, 16'h0fa0);
        chk16(reg_setpoint_mv, 16'h0fa0);
        // Outside supply above, then a short below the window
        ext_mv = 16'h1388;
        ext_on = 1;
        cyc(12);
        chk1(rail_error, 1);
        chk1(status_led, 1);
        ext_on = 0;
        cyc(6);
        lamp = status_led;
        cyc(4);
        chk1(status_led, ~lamp);
        wait_on();
        chk1(rail_error, 0);
        ext_mv = 16'h0000;
        ext_on = 1;
        cyc(12);
        chk1(reg_enable, 0);
        lamp = status_led;
        cyc(4);
        chk1(status_led, ~lamp);
        ext_on = 0;
        wait_on();
        chk1(reg_enable, 1);
        chk16(16'(exp_q.size()), 16'h0000);
        conclude();
    end
    // Watchdog
    initial begin
        #100us;
        err_count++;
        conclude();
    end
endmodule : tb_target_supply_supervisor

/* File: sim/tss_monitor.sv */
// Port checker for the supervisor.
// Assumes the bench's short counts: sample 4, blink 4.
`timescale 1ns/1ps
module tss_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Inputs
    input wire logic supply_disable_input,
    input wire logic [15:0] target_rail_pin,
    input wire logic set_req,
    input wire logic host_access,
    // Outputs
    input wire logic reg_enable,
    input wire logic [15:0] reg_setpoint_mv,
    input wire logic nv_write,
    input wire logic rail_error,
    input wire logic status_led,
    input wire logic pending
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Rail position against the window
    wire under = target_rail_pin < (reg_setpoint_mv - tss_pkg::MV_WINDOW);
    wire over = target_rail_pin > (reg_setpoint_mv + tss_pkg::MV_WINDOW);
    sequence s_over; (rail_error && over)[*8]; endsequence
    sequence s_dim; (rail_error && under && $stable(status_led))[*6]; endsequence
    // Lamp judged once a full sample period has seen the low rail
    sequence s_low; (rail_error && under)[*4]; endsequence
    property p_off; !supply_disable_input |=> !reg_enable; endproperty
    a_off: assert property (p_off) else $error("enable while disabled");
    property p_on; $rose(supply_disable_input) && !rail_error |=> reg_enable; endproperty
    a_on: assert property (p_on) else $error("no enable on release");
    property p_err; rail_error |-> !reg_enable; endproperty
    a_err: assert property (p_err) else $error("enabled in fault");
    property p_det; (reg_enable && (under || over))[*5] |=> rail_error; endproperty
    a_det: assert property (p_det) else $error("fault not seen");
    property p_hw; reg_setpoint_mv >= tss_pkg::MV_HW_LO && reg_setpoint_mv <= tss_pkg::MV_HW_HI;
    endproperty
    a_hw: assert property (p_hw) else $error("setpoint out of range");
    property p_pend; set_req |=> pending; endproperty
    a_pend: assert property (p_pend) else $error("not pending");
    property p_apply; pending && host_access && !set_req |=> nv_write && !pending; endproperty
    a_apply: assert property (p_apply) else $error("access did not apply");
    property p_steady; s_over |-> status_led; endproperty
    a_steady: assert property (p_steady) else $error("lamp not lit");
    property p_blink; s_low |=> not s_dim; endproperty
    a_blink: assert property (p_blink) else $error("lamp not blinking");
endmodule : tss_monitor
bind target_supply_supervisor tss_monitor u_mon (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .supply_disable_input(supply_disable_input),
    .target_rail_pin(target_rail_pin),
    .set_req(set_req),
    .host_access(host_access),
    .reg_enable(reg_enable),
    .reg_setpoint_mv(reg_setpoint_mv),
    .nv_write(nv_write),
    .rail_error(rail_error),
    .status_led(status_led),
    .pending(pending)
);

/* File: sim/tss_rail_model.sv */
// Regulator and rail model for the supervisor bench.
// Assumes the bench steers any outside supply.
`timescale 1ns/1ps
module tss_rail_model (
    // Regulator control
    input wire logic reg_enable,
    input wire logic [15:0] reg_setpoint_mv,
    // Outside supply
    input wire logic ext_on,
    input wire logic [15:0] ext_mv,
    // Measured rail
    output logic [15:0] rail_mv
);
    // Outside supply wins, a disabled regulator collapses the rail
    assign rail_mv = ext_on ? ext_mv : (reg_enable ? reg_setpoint_mv : 16'h0000);
endmodule : tss_rail_model
